// [hdl/srid_hold_timer.sv]
/*
 * srid_hold_timer: flags a level held high for the alarm clear hold time.
 * assumes: a millisecond timebase derived from clk by CYC_PER_MS.
 */
`timescale 1ns/10ps
`default_nettype none
module srid_hold_timer
    import srid_pkg::*;
#(
    parameter int CYC_PER_MS = SRID_CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic level,
    output logic held
);
    logic [SRID_PRE_W-1:0] pre_q;
    logic [SRID_PRE_W-1:0] pre_d;
    logic [SRID_MS_W-1:0] ms_q;
    logic [SRID_MS_W-1:0] ms_d;
    logic held_d;

    always_comb begin
        pre_d = pre_q;
        ms_d = ms_q;
        held_d = held;
        if (!level) begin
            pre_d = '0;
            ms_d = '0;
            held_d = 1'b0;
        end else if (!held) begin
            if (pre_q == SRID_PRE_W'(CYC_PER_MS - 1)) begin
                pre_d = '0;
                ms_d = ms_q + 1'b1;
                if (ms_q == SRID_MS_W'(SRID_RESET_HOLD_MS - 1)) begin
                    held_d = 1'b1;
                end
            end else begin
                pre_d = pre_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= '0;
            ms_q <= '0;
            held <= 1'b0;
        end else if (ce) begin
            pre_q <= pre_d;
            ms_q <= ms_d;
            held <= held_d;
        end
    end
endmodule // srid_hold_timer
`default_nettype wire

// [hdl/srid_pkg.sv]
/*
 * srid_pkg: constants, register map and carrier types for the servo remote input decoder.
 * assumes: a 50 MHz clock and a 32-bit APB register bus.
 */
package srid_pkg;

    localparam int SRID_CLK_HZ = 50_000_000;
    localparam int SRID_MS_PER_S = 1000;
    localparam int SRID_CYC_PER_MS = SRID_CLK_HZ / SRID_MS_PER_S;
    localparam int SRID_RESET_HOLD_MS = 50;
    localparam int SRID_PRE_W = 16;
    localparam int SRID_MS_W = 6;
    localparam int SRID_SYNC_W = 5;
    localparam int SRID_IRQ_W = 4;
    // idle levels of the synchronised pins, forced-stop pin idles high
    localparam logic [SRID_SYNC_W-1:0] SRID_PIN_IDLE = 5'h02;

    localparam logic [7:0] SRID_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SRID_ADDR_RY_IMAGE = 8'h04;
    localparam logic [7:0] SRID_ADDR_POS_CMD = 8'h08;
    localparam logic [7:0] SRID_ADDR_SPEED_CMD = 8'h0C;
    localparam logic [7:0] SRID_ADDR_STATUS = 8'h10;
    localparam logic [7:0] SRID_ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] SRID_ADDR_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] SRID_ADDR_IRQ_CLEAR = 8'h1C;
    localparam logic [7:0] SRID_ADDR_ALARM_CMD = 8'h20;

    localparam int SRID_EV_ALARM_SET = 0;
    localparam int SRID_EV_ALARM_CLR = 1;
    localparam int SRID_EV_FSTOP = 2;
    localparam int SRID_EV_REFRESH = 3;
    localparam int SRID_ALARM_CMD_CLR_HARD = 0;

    // remote input image, one word as the master writes it
    typedef struct packed {
        logic [8:0] spare_hi;
        logic abs_inc_select;
        logic spec_system_select;
        logic gain_set_change;
        logic proportional_only_select;
        logic internal_torque_limit_select;
        logic alarm_clear_2st;
        logic alarm_clear_1st;
        logic [7:0] pt_select;
        logic [6:0] spare_lo;
        logic servo_on;
    } srid_ry_t;

    typedef struct packed {
        logic [27:0] spare;
        logic two_station;
        logic function_select_d1_param;
        logic command_system_param;
        logic direct_spec_select_param;
    } srid_ctrl_t;

    typedef struct packed {
        logic [25:0] spare;
        logic movement_complete;
        logic clear_held;
        logic base_enable;
        logic forced_stop_clear;
        logic hard_alarm;
        logic alarm;
    } srid_status_t;

    typedef struct packed {
        logic prop_only;
        logic int_tl;
        logic alt_gain;
        logic cmd_regs;
        logic pos_inc;
        logic base_en;
        logic dyn_brake;
        logic alarm;
        logic irq;
        logic [7:0] pt_number;
        logic [31:0] pos_cmd;
        logic [15:0] speed_cmd;
    } srid_out_t;

    localparam srid_ctrl_t SRID_CTRL_RST = '0;
    localparam srid_ry_t SRID_RY_RST = '0;

endpackage

// [hdl/srid_sync.sv]
/*
 * srid_sync: two-flop synchroniser for a group of pin levels.
 * assumes: inputs are asynchronous to clk; ce freezes the flops.
 */
`timescale 1ns/10ps
`default_nettype none
module srid_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = ce ? din : meta_q;
        sync_d = ce ? meta_q : dout;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            dout <= sync_d;
        end
    end
endmodule // srid_sync
`default_nettype wire

// [hdl/srid_top.sv]
/*
 * srid_top: remote input decoder of a servo driver with APB register access.
 * assumes: the master writes remote bits over APB, pins arrive asynchronously,
 * one 50 MHz clock with synchronous active-high reset.
 */
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module srid_top
    import srid_pkg::*;
#(
    parameter int CYC_PER_MS = SRID_CYC_PER_MS
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LINK_REFRESH,
    input wire logic ALARM_TRIG,
    input wire logic ALARM_HARD,
    input wire logic FORCED_STOP_N,
    input wire logic MOVEMENT_COMPLETE,
    output logic PROPORTIONAL_ONLY,
    output logic INTERNAL_TORQUE_LIMIT,
    output logic ALT_GAIN_SET,
    output logic CMD_FROM_REGS,
    output logic POS_INCREMENTAL,
    output logic [7:0] PT_NUMBER,
    output logic [31:0] POS_CMD,
    output logic [15:0] SPEED_CMD,
    output logic BASE_ENABLE,
    output logic DYN_BRAKE,
    output logic ALARM,
    output logic IRQ
);
    logic [SRID_SYNC_W-1:0] pins_s;
    logic refresh_s;
    logic trig_s;
    logic hard_s;
    logic fs_ok;
    logic movement_complete_s;
    logic clear_held;
    logic clear_level;

    srid_ctrl_t ctrl_q, ctrl_d;
    srid_ry_t staged_q, staged_d;
    srid_ry_t act_q, act_d;
    logic [31:0] pos_q, pos_d;
    logic [15:0] spd_q, spd_d;
    logic [SRID_IRQ_W-1:0] ists_q, ists_d;
    logic [SRID_IRQ_W-1:0] ien_q, ien_d;
    logic [SRID_IRQ_W-1:0] events;
    logic alarm_q, alarm_d;
    logic hard_q, hard_d;
    logic refresh_prev_q;
    logic fs_prev_q;
    logic pready_d, pslverr_d;
    logic [31:0] prdata_d;
    logic wr_en;
    logic hard_clr;
    srid_out_t out_q, out_d;
    srid_status_t sts;

    // forced stop only on the pin
    srid_sync #(.W(SRID_SYNC_W), .RST_VAL(SRID_PIN_IDLE)) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .din({LINK_REFRESH, ALARM_TRIG, ALARM_HARD, FORCED_STOP_N, MOVEMENT_COMPLETE}),
        .dout(pins_s)
    );
    assign {refresh_s, trig_s, hard_s, fs_ok, movement_complete_s} = pins_s;

    assign clear_level = ctrl_q.two_station ? act_q.alarm_clear_2st : act_q.alarm_clear_1st;

    srid_hold_timer #(.CYC_PER_MS(CYC_PER_MS)) u_hold (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .level(clear_level),
        .held(clear_held)
    );

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == SRID_ADDR_CTRL) || (a == SRID_ADDR_RY_IMAGE) || (a == SRID_ADDR_POS_CMD)
            || (a == SRID_ADDR_SPEED_CMD) || (a == SRID_ADDR_STATUS)
            || (a == SRID_ADDR_IRQ_STATUS) || (a == SRID_ADDR_IRQ_ENABLE)
            || (a == SRID_ADDR_IRQ_CLEAR) || (a == SRID_ADDR_ALARM_CMD);
    endfunction

    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] r);
        wr_hit = en && (a == r);
    endfunction

    always_comb begin
        sts = '0;
        sts.alarm = alarm_q;
        sts.hard_alarm = hard_q;
        sts.forced_stop_clear = fs_ok;
        sts.base_enable = out_q.base_en;
        sts.clear_held = clear_held;
        sts.movement_complete = movement_complete_s;
    end

    // bus slave: one wait state, registered answer
    always_comb begin
        wr_en = PSEL && PENABLE && PREADY && PWRITE;
        pready_d = PSEL && PENABLE && !PREADY;
        pslverr_d = 1'b0;
        prdata_d = '0;
        if (pready_d) begin
            pslverr_d = !addr_ok(PADDR);
            if (!PWRITE) begin
                unique case (PADDR)
                    SRID_ADDR_CTRL: prdata_d = ctrl_q;
                    SRID_ADDR_RY_IMAGE: prdata_d = staged_q;
                    SRID_ADDR_POS_CMD: prdata_d = pos_q;
                    SRID_ADDR_SPEED_CMD: prdata_d = {16'h0000, spd_q};
                    SRID_ADDR_STATUS: prdata_d = sts;
                    SRID_ADDR_IRQ_STATUS: prdata_d = {28'h0000000, ists_q};
                    SRID_ADDR_IRQ_ENABLE: prdata_d = {28'h0000000, ien_q};
                    default: prdata_d = '0;
                endcase
            end
        end
        ctrl_d = wr_hit(wr_en, PADDR, SRID_ADDR_CTRL) ? srid_ctrl_t'(PWDATA) : ctrl_q;
        staged_d = wr_hit(wr_en, PADDR, SRID_ADDR_RY_IMAGE) ? srid_ry_t'(PWDATA) : staged_q;
        pos_d = wr_hit(wr_en, PADDR, SRID_ADDR_POS_CMD) ? PWDATA : pos_q;
        spd_d = wr_hit(wr_en, PADDR, SRID_ADDR_SPEED_CMD) ? PWDATA[15:0] : spd_q;
        ien_d = wr_hit(wr_en, PADDR, SRID_ADDR_IRQ_ENABLE) ? PWDATA[SRID_IRQ_W-1:0] : ien_q;
        hard_clr = wr_hit(wr_en, PADDR, SRID_ADDR_ALARM_CMD) && PWDATA[SRID_ALARM_CMD_CLR_HARD];
    end

    // alarm state, a new alarm wins over any clear
    always_comb begin
        alarm_d = alarm_q;
        hard_d = hard_q;
        // hard class cleared by command only
        if (hard_clr) begin
            alarm_d = 1'b0;
            hard_d = 1'b0;
        end
        if (clear_held && !hard_q) begin
            alarm_d = 1'b0;
        end
        if (trig_s) begin
            alarm_d = 1'b1;
            hard_d = hard_q || hard_s;
        end
    end

    // sticky events, set wins over clear
    always_comb begin
        events = '0;
        events[SRID_EV_ALARM_SET] = alarm_d && !alarm_q;
        events[SRID_EV_ALARM_CLR] = !alarm_d && alarm_q;
        events[SRID_EV_FSTOP] = !fs_ok && fs_prev_q;
        events[SRID_EV_REFRESH] = refresh_s && !refresh_prev_q;
        ists_d = ists_q;
        if (wr_hit(wr_en, PADDR, SRID_ADDR_IRQ_CLEAR)) begin
            ists_d = ists_q & ~PWDATA[SRID_IRQ_W-1:0];
        end
        ists_d = ists_d | events;
        act_d = events[SRID_EV_REFRESH] ? staged_q : act_q;
    end

    always_comb begin
        out_d.prop_only = act_q.proportional_only_select;
        out_d.int_tl = act_q.internal_torque_limit_select;
        out_d.alt_gain = act_q.gain_set_change;
        out_d.cmd_regs = act_q.spec_system_select && ctrl_q.direct_spec_select_param;
        out_d.pos_inc = out_d.cmd_regs && ctrl_q.command_system_param && act_q.abs_inc_select;
        out_d.pt_number = act_q.pt_select;
        out_d.pos_cmd = pos_q;
        out_d.speed_cmd = spd_q;
        out_d.base_en = act_q.servo_on && !alarm_q && fs_ok
            && !(clear_level && ctrl_q.function_select_d1_param);
        out_d.dyn_brake = !fs_ok;
        out_d.alarm = alarm_q;
        out_d.irq = |(ists_q & ien_q);
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ctrl_q <= SRID_CTRL_RST;
            staged_q <= SRID_RY_RST;
            act_q <= SRID_RY_RST;
            pos_q <= '0;
            spd_q <= '0;
            ists_q <= '0;
            ien_q <= '0;
            alarm_q <= 1'b0;
            hard_q <= 1'b0;
            refresh_prev_q <= 1'b0;
            fs_prev_q <= 1'b0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
            out_q <= '0;
        end else if (CE) begin
            ctrl_q <= ctrl_d;
            staged_q <= staged_d;
            act_q <= act_d;
            pos_q <= pos_d;
            spd_q <= spd_d;
            ists_q <= ists_d;
            ien_q <= ien_d;
            alarm_q <= alarm_d;
            hard_q <= hard_d;
            refresh_prev_q <= refresh_s;
            fs_prev_q <= fs_ok;
            PREADY <= pready_d;
            PSLVERR <= pslverr_d;
            PRDATA <= prdata_d;
            out_q <= out_d;
        end
    end

    assign PROPORTIONAL_ONLY = out_q.prop_only;
    assign INTERNAL_TORQUE_LIMIT = out_q.int_tl;
    assign ALT_GAIN_SET = out_q.alt_gain;
    assign CMD_FROM_REGS = out_q.cmd_regs;
    assign POS_INCREMENTAL = out_q.pos_inc;
    assign PT_NUMBER = out_q.pt_number;
    assign POS_CMD = out_q.pos_cmd;
    assign SPEED_CMD = out_q.speed_cmd;
    assign BASE_ENABLE = out_q.base_en;
    assign DYN_BRAKE = out_q.dyn_brake;
    assign ALARM = out_q.alarm;
    assign IRQ = out_q.irq;

    prop_only_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE |=> PROPORTIONAL_ONLY == $past(act_q.proportional_only_select))
        else $error("proportional-only output does not follow remote bit");

    torque_sel_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE |=> INTERNAL_TORQUE_LIMIT == $past(act_q.internal_torque_limit_select))
        else $error("torque limit source does not follow remote bit");

    gain_set_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && act_q.gain_set_change |=> ALT_GAIN_SET)
        else $error("alternate gain set not selected");

    cmd_source_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && !act_q.spec_system_select |=> !CMD_FROM_REGS && PT_NUMBER == $past(act_q.pt_select))
        else $error("point-table command source wrong");

    abs_inc_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && !(act_q.spec_system_select && ctrl_q.command_system_param) |=> !POS_INCREMENTAL)
        else $error("incremental select honoured while invalid");

    alarm_hold_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && alarm_q && !clear_held && !hard_clr |=> alarm_q)
        else $error("alarm cleared before hold time");

    hard_alarm_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && hard_q && !hard_clr |=> hard_q && alarm_q)
        else $error("hard alarm cleared without command");

    base_clear_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && clear_level && ctrl_q.function_select_d1_param |=> !BASE_ENABLE)
        else $error("base stays on under clear with function digit set");

    forced_stop_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && !fs_ok |=> !BASE_ENABLE && DYN_BRAKE)
        else $error("forced stop did not shut base");

    apb_answer_a: assert property (
        @(posedge REF_CLK) disable iff (RST)
        CE && PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("bus access not answered in one cycle");
endmodule // srid_top
`default_nettype wire

// [tb/srid_master_model.sv]
/*
 * srid_master_model: fieldbus master stand-in; APB access and link refresh pulses.
 * assumes: shares the decoder clock; the bench calls its tasks.
 */
`timescale 1ns/10ps
`default_nettype none
module srid_master_model (
    input wire logic clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic link_refresh
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hA5A5_5A5A;
        link_refresh = 1'b0;
    end

    // apb access, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    task automatic refresh();
        @(posedge clk);
        link_refresh <= 1'b1;
        repeat (4) @(posedge clk);
        link_refresh <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule // srid_master_model
`default_nettype wire

// [tb/testbench.sv]
/*
 * testbench: self-checking bench for the servo remote input decoder.
 * assumes: srid_pkg and the design files compiled first; short ms timebase.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench
    import srid_pkg::*;
;
    localparam int CPM = 4;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, refr;
    logic [7:0] paddr, pt_number;
    logic [31:0] pwdata, prdata, pos_cmd;
    logic [15:0] speed_cmd;
    logic alarm_trig, alarm_hard, fsn, mc;
    logic prop, itl, alt, regs, pinc, base, dyn, alarm, irq;
    int fails, check_count;

    srid_top #(.CYC_PER_MS(CPM)) dut_u (.REF_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK_REFRESH(refr),
        .ALARM_TRIG(alarm_trig), .ALARM_HARD(alarm_hard), .FORCED_STOP_N(fsn),
        .MOVEMENT_COMPLETE(mc), .PROPORTIONAL_ONLY(prop), .INTERNAL_TORQUE_LIMIT(itl),
        .ALT_GAIN_SET(alt), .CMD_FROM_REGS(regs), .POS_INCREMENTAL(pinc),
        .PT_NUMBER(pt_number), .POS_CMD(pos_cmd), .SPEED_CMD(speed_cmd),
        .BASE_ENABLE(base), .DYN_BRAKE(dyn), .ALARM(alarm), .IRQ(irq));

    srid_master_model master_u (.clk(clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .link_refresh(refr));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        master_u.apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
        master_u.apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic img(input srid_ry_t v);
        wr(SRID_ADDR_RY_IMAGE, 32'(v));
        master_u.refresh();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse_alarm();
        alarm_trig <= 1'b1;
        cyc(4);
        alarm_trig <= 1'b0;
        cyc(5);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        cyc(2);
        chk("no brake after reset", 32'h0, 32'(dyn));
        rd(SRID_ADDR_CTRL, r, e);
        chk("ctrl reset", 32'h0, r);
        rd(8'h40, r, e);
        chk("unmapped err", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, r);
        wr(SRID_ADDR_POS_CMD, 32'h1234_5678);
        rd(SRID_ADDR_POS_CMD, r, e);
        chk("pos cmd reg", 32'h1234_5678, r);
        $display("test regs done");
    endtask

    task automatic t_decode();
        srid_ry_t v;
        logic [31:0] r;
        logic e;
        v = SRID_RY_RST;
        v.servo_on = 1'b1;
        v.pt_select = 8'hA5;
        v.internal_torque_limit_select = 1'b1;
        v.gain_set_change = 1'b1;
        // prop with torque limit once stopped
        mc <= 1'b1;
        v.proportional_only_select = 1'b1;
        img(v);
        chk("prop only", 32'h1, 32'(prop));
        chk("torque sel", 32'h1, 32'(itl));
        chk("alt gain", 32'h1, 32'(alt));
        chk("pt number", 32'hA5, 32'(pt_number));
        chk("cmd regs", 32'h0, 32'(regs));
        rd(SRID_ADDR_STATUS, r, e);
        chk("status movement_complete", 32'h1, 32'(r[5]));
        v = SRID_RY_RST;
        v.servo_on = 1'b1;
        wr(SRID_ADDR_RY_IMAGE, 32'(v));
        cyc(10);
        chk("staged only", 32'h1, 32'(prop));
        master_u.refresh();
        chk("prop off", 32'h0, 32'(prop));
        chk("torque off", 32'h0, 32'(itl));
        chk("gain off", 32'h0, 32'(alt));
        $display("test decode done");
    endtask

    task automatic t_spec();
        srid_ry_t v;
        wr(SRID_ADDR_CTRL, 32'h3);
        wr(SRID_ADDR_SPEED_CMD, 32'h0000_BEEF);
        v = SRID_RY_RST;
        v.servo_on = 1'b1;
        v.spec_system_select = 1'b1;
        v.abs_inc_select = 1'b1;
        img(v);
        chk("cmd regs", 32'h1, 32'(regs));
        chk("pos cmd", 32'h1234_5678, pos_cmd);
        chk("speed cmd", 32'hBEEF, 32'(speed_cmd));
        chk("incremental", 32'h1, 32'(pinc));
        v.abs_inc_select = 1'b0;
        img(v);
        chk("absolute", 32'h0, 32'(pinc));
        v.abs_inc_select = 1'b1;
        v.spec_system_select = 1'b0;
        img(v);
        chk("abs ignored", 32'h0, 32'(pinc));
        chk("table mode", 32'h0, 32'(regs));
        wr(SRID_ADDR_CTRL, 32'h1);
        v.spec_system_select = 1'b1;
        img(v);
        chk("abs system off", 32'h0, 32'(pinc));
        chk("regs direct", 32'h1, 32'(regs));
        $display("test spec done");
    endtask

    task automatic t_alarm();
        srid_ry_t v;
        logic [31:0] r;
        logic e;
        wr(SRID_ADDR_CTRL, 32'h0);
        wr(SRID_ADDR_IRQ_ENABLE, 32'h1);
        v = SRID_RY_RST;
        v.servo_on = 1'b1;
        img(v);
        chk("base on", 32'h1, 32'(base));
        pulse_alarm();
        chk("alarm set", 32'h1, 32'(alarm));
        chk("base off", 32'h0, 32'(base));
        chk("irq up", 32'h1, 32'(irq));
        rd(SRID_ADDR_IRQ_STATUS, r, e);
        chk("irq status", 32'h1, 32'(r[0]));
        wr(SRID_ADDR_IRQ_CLEAR, 32'hF);
        cyc(2);
        chk("irq cleared", 32'h0, 32'(irq));
        v.alarm_clear_1st = 1'b1;
        img(v);
        cyc(90);
        v.alarm_clear_1st = 1'b0;
        img(v);
        v.alarm_clear_1st = 1'b1;
        img(v);
        cyc(175);
        chk("hold short", 32'h1, 32'(alarm));
        cyc(25);
        chk("alarm cleared", 32'h0, 32'(alarm));
        chk("base kept", 32'h1, 32'(base));
        wr(SRID_ADDR_CTRL, 32'h4);
        cyc(3);
        chk("base shut", 32'h0, 32'(base));
        wr(SRID_ADDR_CTRL, 32'hC);
        cyc(3);
        chk("two station idle", 32'h1, 32'(base));
        v.alarm_clear_2st = 1'b1;
        img(v);
        chk("two station clear", 32'h0, 32'(base));
        wr(SRID_ADDR_CTRL, 32'h0);
        wr(SRID_ADDR_IRQ_ENABLE, 32'h0);
        alarm_hard <= 1'b1;
        pulse_alarm();
        chk("irq masked", 32'h0, 32'(irq));
        cyc(220);
        chk("hard kept", 32'h1, 32'(alarm));
        alarm_hard <= 1'b0;
        v.alarm_clear_1st = 1'b0;
        img(v);
        wr(SRID_ADDR_ALARM_CMD, 32'h1);
        cyc(3);
        chk("hard cleared", 32'h0, 32'(alarm));
        $display("test alarm done");
    endtask

    task automatic t_stop();
        srid_ry_t v;
        v = '1;
        v.alarm_clear_1st = 1'b0;
        v.alarm_clear_2st = 1'b0;
        img(v);
        chk("no remote stop", 32'h0, 32'(dyn));
        chk("base run", 32'h1, 32'(base));
        fsn <= 1'b0;
        cyc(5);
        chk("stop base", 32'h0, 32'(base));
        chk("stop brake", 32'h1, 32'(dyn));
        fsn <= 1'b1;
        cyc(5);
        chk("leave brake", 32'h0, 32'(dyn));
        chk("leave base", 32'h1, 32'(base));
        ce <= 1'b0;
        fsn <= 1'b0;
        cyc(5);
        chk("frozen brake", 32'h0, 32'(dyn));
        ce <= 1'b1;
        cyc(4);
        chk("thawed brake", 32'h1, 32'(dyn));
        fsn <= 1'b1;
        cyc(5);
        chk("thawed leave", 32'h0, 32'(dyn));
        $display("test stop done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        alarm_trig = 1'b0;
        alarm_hard = 1'b0;
        fsn = 1'b1;
        mc = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_decode();
        t_spec();
        t_alarm();
        t_stop();
        final_report();
    end
endmodule // testbench
`default_nettype wire
